/* bench/pwm_8p2_bit_generator_tb.sv */
// Purpose: Self-checking bench for the pulse width modulator.
// Assumes: Registers reached over AHB-Lite; load model counts pin highs.
// Notes:   High counts over one whole output cycle do not depend on phase.
`timescale 1ns/100ps
`default_nettype none
module pwm_8p2_bit_generator_tb;
  logic        clk;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, halt = 1'b0, stop = 1'b0, start = 1'b0;
  logic        pdata = 1'b0, poe = 1'b0, ppull = 1'b0, v;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'hFDC4;
  logic [1:0]  htrans = 2'h0, sel;
  logic [2:0]  hsize = 3'h2;
  logic        hready, hresp, pin, pin_oe, pin_pu, done, pol;
  logic [15:0] win = 16'h0, count;
  logic [7:0]  p, d;
  logic [1:0]  f;
  int          mismatches = 0, total_checks = 0, w, hi, ex;
  logic [31:0] exp_q[$];

  pwm_8p2_generator uut (.ref_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .halt_mode_in(halt),
    .stop_mode_in(stop), .port_data_in(pdata), .port_oe_in(poe),
    .port_pullup_in(ppull), .shared_port_pin_out(pin),
    .shared_port_pin_oe_out(pin_oe), .shared_port_pullup_out(pin_pu));
  pwm_load_model load (.clk_in(clk), .rst_n_in(rst_n), .pin_in(pin), .oe_in(pin_oe),
    .pullup_in(pin_pu), .start_in(start), .win_in(win), .done_out(done),
    .count_out(count));

  // Clock of 4 ns.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction : lfsr

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One single transfer; waits for ready in both phases.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= pwm_mod_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) begin
      @(posedge clk);
    end
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) begin
      @(posedge clk);
    end
    rd = hrdata;
    chk("response", {31'h0, pwm_mod_pkg::HRESP_OKAY}, {31'h0, hresp});
  endtask : bus

  // Writes a nibble with random upper data bits.
  task automatic wr(input logic [7:0] idx, input logic [3:0] nib);
    seed = lfsr(seed);
    bus(1'b1, idx, {seed[31:4], nib});
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // Compares each finished window with the oldest expected count.
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected window", 32'h1, 32'h0);
      else chk("high count", exp_q.pop_front(), {16'h0, count});
    end
  end

  // Cuts a hang short.
  initial begin
    #200000;
    mismatches++;
    close_out();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("control", pwm_mod_pkg::IDX_CONTROL, {28'h0, pwm_mod_pkg::CTRL_RESET});
    rdchk("period", pwm_mod_pkg::IDX_PERIOD_HIGH, 32'h0);
    rdchk("duty", pwm_mod_pkg::IDX_DUTY_HIGH, 32'h0);
    wr(8'h21, 4'hF);
    rdchk("unmapped", 8'h21, 32'h0);
    seed = lfsr(seed);
    pdata <= seed[0];
    poe   <= ~seed[0];
    ppull <= seed[1];
    repeat (2) @(posedge clk);
    chk("port value", {31'h0, pdata}, {31'h0, pin});
    chk("port enable", {31'h0, poe}, {31'h0, pin_oe});
    chk("port pull", {31'h0, ppull}, {31'h0, pin_pu});
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      sel = i[1:0];
      pol = (i < 4) ? i[0] : seed[0];
      p = (i < 2) ? 8'h0 : (i < 4) ? 8'h5 : 8'h2 + {3'h0, seed[12:8]};
      d = (i < 4) ? ((i == 3) ? 8'h9 : 8'h5) : {3'h0, seed[20:16]} % p;
      f = seed[25:24];
      w = (p == 8'h0) ? 64 : 4 * int'(p) * (1 << sel);
      hi = (4 * int'(d) + int'(f)) * (1 << sel);
      ex = (p == 8'h0) ? (pol ? w : 0) : (p <= d) ? (pol ? 0 : w) : (pol ? hi : w - hi);
      wr(pwm_mod_pkg::IDX_CONTROL, {pol, sel, 1'b1});
      wr(pwm_mod_pkg::IDX_DUTY_FRAC, {seed[27:26], f});
      wr(pwm_mod_pkg::IDX_DUTY_LOW, d[3:0]);
      wr(pwm_mod_pkg::IDX_DUTY_HIGH, d[7:4]);
      wr(pwm_mod_pkg::IDX_PERIOD_LOW, p[3:0]);
      wr(pwm_mod_pkg::IDX_PERIOD_HIGH, p[7:4]);
      rdchk("control", pwm_mod_pkg::IDX_CONTROL, {28'h0, pol, sel, 1'b1});
      rdchk("period hi", pwm_mod_pkg::IDX_PERIOD_HIGH, {28'h0, p[7:4]});
      rdchk("period lo", pwm_mod_pkg::IDX_PERIOD_LOW, {28'h0, p[3:0]});
      rdchk("duty hi", pwm_mod_pkg::IDX_DUTY_HIGH, {28'h0, d[7:4]});
      rdchk("duty lo", pwm_mod_pkg::IDX_DUTY_LOW, {28'h0, d[3:0]});
      rdchk("duty fine", pwm_mod_pkg::IDX_DUTY_FRAC, {30'h0, f});
      seed = lfsr(seed);
      halt  <= seed[28];
      pdata <= seed[29];
      poe   <= seed[30];
      ppull <= seed[31];
      repeat (300 + w) @(posedge clk);
      chk("pin enable", 32'h1, {31'h0, pin_oe});
      chk("pin pull", 32'h0, {31'h0, pin_pu});
      exp_q.push_back(ex[31:0]);
      start <= 1'b1;
      win   <= w[15:0];
      @(posedge clk);
      start <= 1'b0;
      repeat (w + 4) @(posedge clk);
    end
    // Stop mode must freeze the output level.
    stop <= 1'b1;
    repeat (3) @(posedge clk);
    v = pin;
    repeat (300) begin
      @(posedge clk);
      chk("frozen pin", {31'h0, v}, {31'h0, pin});
    end
    stop <= 1'b0;
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule : pwm_8p2_bit_generator_tb
`default_nettype wire

/* bench/pwm_load_model.sv */
// Purpose: Load on the shared pin; counts high samples over a window.
// Assumes: Pin level resolved from drive enable and pull-up enable.
// Notes:   An undriven pin without pull-up toggles every cycle.
`timescale 1ns/100ps
`default_nettype none
module pwm_load_model (
  input  wire logic        clk_in,     // Bench clock.
  input  wire logic        rst_n_in,   // Reset, active low.
  input  wire logic        pin_in,     // Pin value.
  input  wire logic        oe_in,      // Pin drive enable.
  input  wire logic        pullup_in,  // Pull-up enable.
  input  wire logic        start_in,   // Starts a window.
  input  wire logic [15:0] win_in,     // Window length in cycles.
  output logic             done_out,   // Window over, one cycle.
  output logic      [15:0] count_out   // High samples seen.
);
  logic        level;
  logic        float_ff;
  logic [15:0] left_ff;
  // A pin nobody drives or pulls must not look like a steady value.
  assign level = oe_in ? pin_in : (pullup_in | float_ff);
  // Count high samples until the window runs out.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      float_ff  <= 1'b0;
      left_ff   <= 16'h0;
      done_out  <= 1'b0;
      count_out <= 16'h0;
    end else begin
      float_ff <= ~float_ff;
      done_out <= 1'b0;
      if (start_in) begin
        left_ff   <= win_in;
        count_out <= 16'h0;
      end else if (left_ff != 16'h0) begin
        left_ff   <= left_ff - 16'h1;
        count_out <= count_out + {15'h0, level};
        done_out  <= (left_ff == 16'h1);
      end
    end
  end
endmodule : pwm_load_model
`default_nettype wire

/* src/pwm_8p2_generator.sv */
// Purpose: (8+2)-bit pulse width modulator with prescaler, behind an AHB-Lite slave.
// Assumes: One clock; all inputs synchronous to it; single word transfers only.
// Notes:   New period and duty values are applied only at a period start.
`timescale 1ns/100ps
`default_nettype none

module pwm_8p2_generator #(
  parameter int PERIOD_W = 8                         // Width of period and duty values.
) (
  input  wire logic        ref_clk_in,               // System clock, 250 MHz.
  input  wire logic        rst_n_in,                 // Asynchronous reset, active low.
  input  wire logic        hsel_in,                  // Slave select.
  input  wire logic [31:0] haddr_in,                 // Byte address.
  input  wire logic [1:0]  htrans_in,                // Transfer type.
  input  wire logic        hwrite_in,                // Write when high.
  input  wire logic [2:0]  hsize_in,                 // Transfer size.
  input  wire logic        hready_in,                // Bus ready.
  input  wire logic [31:0] hwdata_in,                // Write data.
  output logic      [31:0] hrdata_out,               // Read data.
  output logic             hreadyout_out,            // Slave ready.
  output logic             hresp_out,                // Response, always OKAY.
  input  wire logic        halt_mode_in,             // Core halted; modulator keeps running.
  input  wire logic        stop_mode_in,             // Stop mode; modulator freezes.
  input  wire logic        port_data_in,             // Port output value.
  input  wire logic        port_oe_in,               // Port output enable.
  input  wire logic        port_pullup_in,           // Port pull-up request.
  output logic             shared_port_pin_out,      // Pin output value.
  output logic             shared_port_pin_oe_out,   // Pin output enable.
  output logic             shared_port_pullup_out    // Pin pull-up enable.
);

  // Refuse widths that the nibble registers cannot carry.
  if (PERIOD_W != 8) begin : g_width_check
    $error("PERIOD_W must be 8");
  end

  pwm_mod_pkg::pwm_state_t s_ff;
  pwm_mod_pkg::pwm_state_t nxt_s;

  logic             addr_phase;
  logic [7:0]       addr_idx;
  logic [2:0]       div_limit;
  logic             tick;
  logic             period_start;
  logic [8:0]       width;
  logic             polarity;
  logic             halt_seen;

  // Address phase decode; the index is the word address.
  assign addr_phase = hsel_in && hready_in && (htrans_in == pwm_mod_pkg::HTRANS_NONSEQ);
  assign addr_idx   = haddr_in[pwm_mod_pkg::ADDR_W-1:2];
  assign polarity   = s_ff.control[pwm_mod_pkg::CTRL_POLARITY];
  assign halt_seen  = halt_mode_in;  // Halt has no effect on the modulator.

  // Prescaler terminal count from the clock select field.
  always_comb begin
    unique case (s_ff.control[pwm_mod_pkg::CTRL_PRESCALE_LO +: 2])
      2'h0: div_limit = pwm_mod_pkg::DIV_LIMIT_1;
      2'h1: div_limit = pwm_mod_pkg::DIV_LIMIT_2;
      2'h2: div_limit = pwm_mod_pkg::DIV_LIMIT_4;
      2'h3: div_limit = pwm_mod_pkg::DIV_LIMIT_8;
    endcase
  end

  // One modulator clock enable per prescaled period; none in stop mode.
  assign tick = !stop_mode_in && (s_ff.div_cnt >= div_limit);

  // A period ends on the tick that reaches the programmed length.
  assign period_start = tick && ((s_ff.period_act == 8'h00) ||
                                 (s_ff.mod_cnt >= s_ff.period_act - 8'h01));

  // Active width: duty, plus one clock in cycles below the fine-tune value.
  assign width = {1'b0, s_ff.duty_act} +
                 {8'h00, (s_ff.mod_idx < s_ff.fine_act)};

  // Next state: prescaler, period counter, reload, bus writes and read data.
  always_comb begin
    logic [7:0] nw;
    logic [8:0] wnx;
    logic       act;
    nw    = 8'h00;
    wnx   = 9'h000;
    act   = 1'b0;
    nxt_s = s_ff;

    if (!stop_mode_in) begin
      nxt_s.div_cnt = tick ? 3'h0 : s_ff.div_cnt + 3'h1;
    end

    // Counter wraps at the period end and steps the modulation cycle.
    if (period_start) begin
      nxt_s.mod_cnt = 8'h00;
      nxt_s.mod_idx = s_ff.mod_idx + 2'h1;
      if (s_ff.reload_pend) begin
        nxt_s.period_act  = s_ff.period_pend;
        nxt_s.duty_act    = s_ff.duty_pend;
        nxt_s.fine_act    = s_ff.fine_pend;
        nxt_s.reload_pend = 1'b0;
      end
    end else if (tick) begin
      nxt_s.mod_cnt = s_ff.mod_cnt + 8'h01;
    end

    // Bus write data phase; a write that meets a reload keeps its flag.
    nxt_s.wr_pend = addr_phase && hwrite_in;
    nxt_s.wr_idx  = addr_idx;
    if (s_ff.wr_pend) begin
      unique case (s_ff.wr_idx)
        pwm_mod_pkg::IDX_CONTROL:     nxt_s.control = hwdata_in[3:0];
        pwm_mod_pkg::IDX_PERIOD_LOW:  nxt_s.period_low = hwdata_in[3:0];
        pwm_mod_pkg::IDX_PERIOD_HIGH: begin
          nxt_s.period_high = hwdata_in[3:0];
          nxt_s.period_pend = {hwdata_in[3:0], s_ff.period_low};
          nxt_s.duty_pend   = {s_ff.duty_high, s_ff.duty_low};
          nxt_s.fine_pend   = s_ff.duty_fine;
          nxt_s.reload_pend = 1'b1;
        end
        pwm_mod_pkg::IDX_DUTY_FRAC:   nxt_s.duty_fine = hwdata_in[1:0];
        pwm_mod_pkg::IDX_DUTY_LOW:    nxt_s.duty_low = hwdata_in[3:0];
        pwm_mod_pkg::IDX_DUTY_HIGH: begin
          nxt_s.duty_high   = hwdata_in[3:0];
          nxt_s.period_pend = {s_ff.period_high, s_ff.period_low};
          nxt_s.duty_pend   = {hwdata_in[3:0], s_ff.duty_low};
          nxt_s.fine_pend   = s_ff.duty_fine;
          nxt_s.reload_pend = 1'b1;
        end
        default: nxt_s.wr_pend = nxt_s.wr_pend;  // Unmapped writes are dropped.
      endcase
    end

    // Read data for the coming data phase, taken after any write lands.
    nxt_s.rdata = 32'h0000_0000;
    if (addr_phase && !hwrite_in) begin
      unique case (addr_idx)
        pwm_mod_pkg::IDX_CONTROL:     nxt_s.rdata[3:0] = nxt_s.control;
        pwm_mod_pkg::IDX_PERIOD_LOW:  nxt_s.rdata[3:0] = nxt_s.period_low;
        pwm_mod_pkg::IDX_PERIOD_HIGH: nxt_s.rdata[3:0] = nxt_s.period_high;
        pwm_mod_pkg::IDX_DUTY_FRAC:   nxt_s.rdata[1:0] = nxt_s.duty_fine;
        pwm_mod_pkg::IDX_DUTY_LOW:    nxt_s.rdata[3:0] = nxt_s.duty_low;
        pwm_mod_pkg::IDX_DUTY_HIGH:   nxt_s.rdata[3:0] = nxt_s.duty_high;
        default:                      nxt_s.rdata = 32'h0000_0000;
      endcase
    end

    // Output level for the next state: active from period start for the width while the period is nonzero and above the duty.
    nw  = nxt_s.mod_cnt;
    wnx = {1'b0, nxt_s.duty_act} + {8'h00, (nxt_s.mod_idx < nxt_s.fine_act)};
    act = {1'b0, nw} < wnx;
    if (nxt_s.period_act == 8'h00) begin
      nxt_s.wave = nxt_s.control[pwm_mod_pkg::CTRL_POLARITY];
    end else if (nxt_s.period_act <= nxt_s.duty_act) begin
      nxt_s.wave = !nxt_s.control[pwm_mod_pkg::CTRL_POLARITY];
    end else begin
      nxt_s.wave = nxt_s.control[pwm_mod_pkg::CTRL_POLARITY] ? act : !act;
    end
  end

  // State register.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff         <= '0;
      s_ff.control <= pwm_mod_pkg::CTRL_RESET;
      s_ff.wave    <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Bus answers at once with OKAY.
  assign hrdata_out    = s_ff.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = pwm_mod_pkg::HRESP_OKAY;

  // Pin sharing: the modulator takes the pin and drops port drive and pull-up.
  assign shared_port_pin_out    = s_ff.control[pwm_mod_pkg::CTRL_PIN_EN_BIT] ?
                                  s_ff.wave : port_data_in;
  assign shared_port_pin_oe_out = s_ff.control[pwm_mod_pkg::CTRL_PIN_EN_BIT] ||
                                  port_oe_in;
  assign shared_port_pullup_out = !s_ff.control[pwm_mod_pkg::CTRL_PIN_EN_BIT] &&
                                  port_pullup_in;

  // Ticks eight reference clocks apart when the slowest clock is selected.
  sequence slow_tick_s;
    tick && (s_ff.control[2:1] == 2'h3) && !stop_mode_in;
  endsequence

  sequence slow_hold_s;
    ((s_ff.control[2:1] == 2'h3) && !stop_mode_in && !s_ff.wr_pend) [*8];
  endsequence

  chk_prescale_eight: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    slow_tick_s ##1 slow_hold_s |-> tick && $past(!tick, 1) && $past(!tick, 7))
    else $error("prescaler tick spacing wrong for eight-clock select");

  chk_pin_mux_on: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_ff.control[0] |-> (shared_port_pin_out == s_ff.wave) && shared_port_pin_oe_out)
    else $error("enabled pin does not carry modulator output");

  chk_pullup_off: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_ff.control[0] |-> !shared_port_pullup_out)
    else $error("pull-up active while modulator owns pin");

  chk_zero_period: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_ff.period_act == 8'h00) |-> (s_ff.wave == polarity))
    else $error("zero period level wrong");

  chk_full_duty: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_ff.period_act != 8'h00) && (s_ff.period_act <= s_ff.duty_act) |->
      (s_ff.wave == !polarity))
    else $error("saturated duty level wrong");

  chk_start_active: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_ff.mod_cnt == 8'h00) && (s_ff.duty_act != 8'h00) &&
      (s_ff.period_act > s_ff.duty_act) |-> (s_ff.wave == polarity))
    else $error("period does not open at the active level");

  chk_stop_freeze: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    stop_mode_in ##1 stop_mode_in |-> $stable(s_ff.mod_cnt) && $stable(s_ff.mod_idx))
    else $error("modulator moved in stop mode");

  chk_reload_defer: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    $changed(s_ff.period_act) || $changed(s_ff.duty_act) |-> $past(period_start))
    else $error("new value applied outside a period start");

  chk_cycle_step: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    $changed(s_ff.mod_idx) |-> $past(period_start) && (s_ff.mod_cnt == 8'h00) &&
      (s_ff.mod_idx == $past(s_ff.mod_idx) + 2'h1))
    else $error("modulation cycle stepped off a period end");

  chk_fine_width: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_ff.mod_cnt == s_ff.duty_act) &&
      ({1'b0, s_ff.period_act} > ({1'b0, s_ff.duty_act} + 9'h001)) &&
      (s_ff.mod_idx < s_ff.fine_act) |-> (s_ff.wave == polarity))
    else $error("fine-tune extra clock missing");

  chk_bus_okay: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    hreadyout_out && (hresp_out == pwm_mod_pkg::HRESP_OKAY))
    else $error("bus answer not ready and okay");

  // Read data stands only in the data phase that follows a read address phase.
  chk_read_idle: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !$past(addr_phase && !hwrite_in) |-> (hrdata_out == 32'h0000_0000))
    else $error("read data shown outside a data phase");

  // Halt must not hold back the prescaler; only stop may do that.
  chk_halt_runs: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    halt_seen && !stop_mode_in && (s_ff.div_cnt >= div_limit) |-> tick)
    else $error("modulator stalled in halt mode");

  // The level follows the registered count against the active width.
  chk_active_width: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_ff.period_act != 8'h00) && (s_ff.period_act > s_ff.duty_act) |->
      (s_ff.wave == (({1'b0, s_ff.mod_cnt} < width) ? polarity : !polarity)))
    else $error("active width does not match the count");

  // The count never runs past the period in use, even after a shorter reload.
  chk_count_bound: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_ff.period_act != 8'h00) |-> (s_ff.mod_cnt < s_ff.period_act))
    else $error("period counter ran past the period");

  // A waiting reload lands whole at the period start, all three values together.
  chk_reload_apply: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    period_start && s_ff.reload_pend |=>
      (s_ff.period_act == $past(s_ff.period_pend)) &&
      (s_ff.duty_act == $past(s_ff.duty_pend)) &&
      (s_ff.fine_act == $past(s_ff.fine_pend)))
    else $error("pending values not applied at the period start");

  // With the enable bit clear the pin belongs to the port unchanged.
  chk_pin_mux_off: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !s_ff.control[0] |-> (shared_port_pin_out == port_data_in) &&
      (shared_port_pin_oe_out == port_oe_in) &&
      (shared_port_pullup_out == port_pullup_in))
    else $error("disabled pin does not follow the port");

endmodule : pwm_8p2_generator

`default_nettype wire

/* src/pwm_mod_pkg.sv */
// Purpose: Shared constants and state layout for the (8+2)-bit pulse width modulator.
// Assumes: AHB-Lite register access, one word per nibble register.
// Notes:   Byte address of a register is four times its index.
package pwm_mod_pkg;

  // Register indices on the bus; the byte address is four times the index.
  localparam logic [7:0] IDX_CONTROL     = 8'h20;
  localparam logic [7:0] IDX_PERIOD_LOW  = 8'h22;
  localparam logic [7:0] IDX_PERIOD_HIGH = 8'h23;
  localparam logic [7:0] IDX_DUTY_FRAC   = 8'h24;
  localparam logic [7:0] IDX_DUTY_LOW    = 8'h25;
  localparam logic [7:0] IDX_DUTY_HIGH   = 8'h26;
  localparam int         ADDR_W          = 10;

  // Control register field positions and reset value.
  localparam int         CTRL_PIN_EN_BIT  = 0;
  localparam int         CTRL_PRESCALE_LO = 1;
  localparam int         CTRL_POLARITY    = 3;
  localparam logic [3:0] CTRL_RESET       = 4'h8;

  // Prescaler terminal counts for 1, 2, 4 and 8 oscillator periods.
  localparam logic [2:0] DIV_LIMIT_1 = 3'h0;
  localparam logic [2:0] DIV_LIMIT_2 = 3'h1;
  localparam logic [2:0] DIV_LIMIT_4 = 3'h3;
  localparam logic [2:0] DIV_LIMIT_8 = 3'h7;

  // Bus constants.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Whole state of the modulator and its bus slave.
  typedef struct packed {
    logic [3:0]  control;       // Pin enable, prescale select, polarity.
    logic [3:0]  period_low;    // Buffered period bits 3:0.
    logic [3:0]  period_high;   // Buffered period bits 7:4.
    logic [1:0]  duty_fine;     // Buffered fine-tune bits.
    logic [3:0]  duty_low;      // Buffered duty bits 3:0.
    logic [3:0]  duty_high;     // Buffered duty bits 7:4.
    logic [7:0]  period_act;    // Period in use.
    logic [7:0]  duty_act;      // Duty in use.
    logic [1:0]  fine_act;      // Fine-tune in use.
    logic [7:0]  period_pend;   // Period waiting for the next period start.
    logic [7:0]  duty_pend;     // Duty waiting for the next period start.
    logic [1:0]  fine_pend;     // Fine-tune waiting for the next period start.
    logic        reload_pend;   // A new value waits for the next period start.
    logic [2:0]  div_cnt;       // Prescaler count.
    logic [7:0]  mod_cnt;       // Position inside the current period.
    logic [1:0]  mod_idx;       // Modulation cycle number 0 to 3.
    logic        wave;          // Modulator output level.
    logic        wr_pend;       // A write data phase is due.
    logic [7:0]  wr_idx;        // Register index of that write.
    logic [31:0] rdata;         // Read data for the data phase.
  } pwm_state_t;

endpackage : pwm_mod_pkg
